// file: design/pacc_top.sv
// Local design decisions: the register offsets and the strobed register port.
module pacc_top
    import pacc_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [PACC_ADDR_W-1:0] i_addr,
    input wire logic [PACC_DATA_W-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [PACC_DATA_W-1:0] o_rd_data,
    // Oscillator sources
    input wire logic [PACC_SRC_N-1:0] i_osc_src,
    // Oscillator output and interrupt
    output logic o_osc_out,
    output logic o_irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pacc_tick_if tick_if (); // Clock select and tick carrier
    logic [19:0] acc; // Phase accumulator
    logic [19:0] inc_reg; // Software-visible increment
    logic [19:0] inc_buf; // Buffer used by the adder
    logic [19:0] next_inc; // Increment after a byte write
    logic [20:0] acc_sum; // Sum with carry
    logic [1:0] pend_cnt; // Ticks left until commit
    logic ctl_en; // Oscillator enable
    logic ctl_pol; // Output inverted when set
    logic ctl_pfm; // Pulse mode when set
    logic [2:0] pws; // Pulse width select
    logic [1:0] cks; // Clock source select
    logic status; // Sticky overflow flag
    logic mask; // Overflow interrupt enable
    logic toggle_level; // Toggle-mode level
    logic [7:0] pulse_cnt; // Remaining pulse periods
    pacc_pulse_t pulse_state; // Pulse output state
    logic tick; // Oscillator edge
    logic acc_wr; // Software writes accumulator
    logic inc_wr; // Software writes increment
    logic overflow; // Carry out of the top bit
    logic commit; // Move increment into buffer
    logic active; // Output active before polarity

    // ------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------
    assign tick_if.clk_sel = cks;
    assign tick = tick_if.tick;

    pacc_clk_sel u_clk_sel (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_osc_src(i_osc_src),
        .tick_if(tick_if)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Any accumulator byte write
    assign acc_wr = i_wr_en && (i_addr == PACC_OFS_ACC_LOW ||
        i_addr == PACC_OFS_ACC_HIGH || i_addr == PACC_OFS_ACC_UPPER);
    // Any increment byte write
    assign inc_wr = i_wr_en && (i_addr == PACC_OFS_INC_LOW ||
        i_addr == PACC_OFS_INC_HIGH || i_addr == PACC_OFS_INC_UPPER);

    // ------------------------------------------------------------
    // Adder and overflow
    // ------------------------------------------------------------
    assign acc_sum = {1'b0, acc} + {1'b0, inc_buf};
    // A software write to the accumulator suppresses that step
    assign overflow = tick && ctl_en && !acc_wr && acc_sum[20];

    // Accumulator: software write wins over a tick
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc <= PACC_ACC_RST;
        end else if (i_wr_en && i_addr == PACC_OFS_ACC_LOW) begin
            acc[7:0] <= i_wr_data;
        end else if (i_wr_en && i_addr == PACC_OFS_ACC_HIGH) begin
            acc[15:8] <= i_wr_data;
        end else if (i_wr_en && i_addr == PACC_OFS_ACC_UPPER) begin
            acc[19:16] <= i_wr_data[3:0];
        end else if (tick && ctl_en) begin
            acc <= acc_sum[19:0];
        end
    end

    // ------------------------------------------------------------
    // Increment registers and double buffer
    // ------------------------------------------------------------
    // Merge the written byte into the increment
    always_comb begin
        next_inc = inc_reg;
        case (i_addr)
            PACC_OFS_INC_LOW: begin
                next_inc[7:0] = i_wr_data;
            end
            PACC_OFS_INC_HIGH: begin
                next_inc[15:8] = i_wr_data;
            end
            PACC_OFS_INC_UPPER: begin
                next_inc[19:16] = i_wr_data[3:0];
            end
            default: begin
                next_inc = inc_reg;
            end
        endcase
    end

    // Visible increment, bit 0 resets to one
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            inc_reg <= PACC_INC_RST;
        end else if (inc_wr) begin
            inc_reg <= next_inc;
        end
    end

    // Commit countdown, started only by the low byte while running
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend_cnt <= 2'h0;
        end else if (i_wr_en && i_addr == PACC_OFS_INC_LOW && ctl_en) begin
            pend_cnt <= PACC_COMMIT_TICKS;
        end else if (!ctl_en || (tick && pend_cnt != 2'h0)) begin
            pend_cnt <= ctl_en ? pend_cnt - 2'h1 : 2'h0;
        end
    end

    // Second tick commits; disabling flushes a waiting commit
    assign commit = (tick && ctl_en && pend_cnt == 2'h1) ||
        (!ctl_en && pend_cnt != 2'h0);

    // Buffer; while enabled, high and upper writes rely on a later low write
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            inc_buf <= PACC_INC_RST;
        end else if (inc_wr && !ctl_en) begin
            inc_buf <= next_inc;
        end else if (commit) begin
            inc_buf <= inc_reg;
        end
    end

    // ------------------------------------------------------------
    // Control and clock registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_en <= 1'b0;
            ctl_pol <= 1'b0;
            ctl_pfm <= 1'b0;
        end else if (i_wr_en && i_addr == PACC_OFS_CONTROL) begin
            ctl_en <= i_wr_data[PACC_CTL_EN_BIT];
            ctl_pol <= i_wr_data[PACC_CTL_POL_BIT];
            ctl_pfm <= i_wr_data[PACC_CTL_PFM_BIT];
        end
    end

    // Pulse width and source select
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pws <= 3'h0;
            cks <= 2'h0;
        end else if (i_wr_en && i_addr == PACC_OFS_CLOCK) begin
            pws <= i_wr_data[PACC_CLK_PWS_LSB +: 3];
            cks <= i_wr_data[PACC_CLK_CKS_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Output generation
    // ------------------------------------------------------------
    // Toggle mode level
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            toggle_level <= 1'b0;
        end else if (overflow && !ctl_pfm) begin
            toggle_level <= ~toggle_level;
        end
    end

    // Pulse mode: width counted in oscillator ticks
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pulse_state <= PACC_PULSE_IDLE;
            pulse_cnt <= 8'h00;
        end else if (overflow && ctl_pfm) begin
            // Reload; overlap is undefined, restart is simplest
            pulse_state <= PACC_PULSE_ACTIVE;
            pulse_cnt <= PACC_PULSE_ONE << pws;
        end else begin
            case (pulse_state)
                PACC_PULSE_IDLE: begin
                    pulse_cnt <= 8'h00;
                end
                PACC_PULSE_ACTIVE: begin
                    // Last period ends on the Nth tick
                    if (tick && pulse_cnt == PACC_PULSE_ONE) begin
                        pulse_state <= PACC_PULSE_IDLE;
                        pulse_cnt <= 8'h00;
                    end else if (tick) begin
                        pulse_cnt <= pulse_cnt - 8'h01;
                    end
                end
                default: begin
                    pulse_state <= PACC_PULSE_IDLE;
                end
            endcase
        end
    end

    // Mode select before polarity
    assign active = ctl_pfm ? (pulse_state == PACC_PULSE_ACTIVE) : toggle_level;

    // Registered pin with polarity
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_osc_out <= 1'b0;
        end else begin
            o_osc_out <= active ^ ctl_pol;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and line
    // ------------------------------------------------------------
    // Set wins over the clear-on-read
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status <= 1'b0;
        end else begin
            status <= overflow ||
                (status && !(i_rd_en && i_addr == PACC_OFS_STATUS));
        end
    end

    // Mask register
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask <= 1'b0;
        end else if (i_wr_en && i_addr == PACC_OFS_MASK) begin
            mask <= i_wr_data[0];
        end
    end

    // Level interrupt, one cycle behind the flag
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= status && mask;
        end
    end

    // ------------------------------------------------------------
    // Read port: data valid only in the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= 8'h00;
        end else if (i_rd_en) begin
            case (i_addr)
                PACC_OFS_ACC_LOW: o_rd_data <= acc[7:0];
                PACC_OFS_ACC_HIGH: o_rd_data <= acc[15:8];
                PACC_OFS_ACC_UPPER: o_rd_data <= {4'h0, acc[19:16]};
                PACC_OFS_INC_LOW: o_rd_data <= inc_reg[7:0];
                PACC_OFS_INC_HIGH: o_rd_data <= inc_reg[15:8];
                PACC_OFS_INC_UPPER: o_rd_data <= {4'h0, inc_reg[19:16]};
                PACC_OFS_CONTROL: begin
                    o_rd_data <= {ctl_en, 1'b0, o_osc_out, ctl_pol, 3'h0, ctl_pfm};
                end
                PACC_OFS_CLOCK: o_rd_data <= {pws, 3'h0, cks};
                PACC_OFS_STATUS: o_rd_data <= {7'h00, status};
                PACC_OFS_MASK: o_rd_data <= {7'h00, mask};
                default: o_rd_data <= 8'h00; // Unmapped reads zero
            endcase
        end else begin
            o_rd_data <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_acc_low_read;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_rd_en && i_addr == PACC_OFS_ACC_LOW) |=> o_rd_data == $past(acc[7:0]);
    endproperty
    a_acc_low_read: assert property (p_acc_low_read)
        else $error("accumulator low byte read mismatch");

    property p_acc_upper_zero;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_rd_en && i_addr == PACC_OFS_ACC_UPPER) |=> o_rd_data[7:4] == 4'h0;
    endproperty
    a_acc_upper_zero: assert property (p_acc_upper_zero)
        else $error("accumulator upper nibble top bits not zero");

    property p_inc_low_write;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_wr_en && i_addr == PACC_OFS_INC_LOW) |=> inc_reg[7:0] == $past(i_wr_data);
    endproperty
    a_inc_low_write: assert property (p_inc_low_write)
        else $error("increment low byte not stored");

    property p_inc_upper_zero;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_rd_en && i_addr == PACC_OFS_INC_UPPER) |=> o_rd_data[7:4] == 4'h0;
    endproperty
    a_inc_upper_zero: assert property (p_inc_upper_zero)
        else $error("increment upper nibble top bits not zero");

    property p_acc_step;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (tick && ctl_en && !acc_wr) |=> acc == 20'($past(acc) + $past(inc_buf));
    endproperty
    a_acc_step: assert property (p_acc_step)
        else $error("accumulator did not add the increment");

    property p_load_disabled;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (inc_wr && !ctl_en) |=> inc_buf == inc_reg;
    endproperty
    a_load_disabled: assert property (p_load_disabled)
        else $error("increment buffer not loaded while disabled");

    property p_toggle_step;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (overflow && !ctl_pfm) |=> toggle_level != $past(toggle_level);
    endproperty
    a_toggle_step: assert property (p_toggle_step)
        else $error("toggle mode missed an overflow");

    property p_pulse_width;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (overflow && ctl_pfm) |=> pulse_cnt == (PACC_PULSE_ONE << $past(pws));
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse width load wrong");

    property p_flag_set;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        overflow |=> status ##1 o_irq == $past(mask);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("overflow flag or interrupt line wrong");
endmodule

// file: common/pacc_pkg.sv
// Behaviour
// - Accumulator bits 7..0 as low byte
// - Accumulator bits 15..8 as high byte
// - Accumulator bits 19..16 in upper, rest zero
// - Increment low byte, bit 0 resets one
// - Increment bits 15..8 as high byte
// - Increment bits 19..16 in upper, rest zero
// - Accumulator adds buffered increment each tick while enabled
// - Commit on second tick, or immediately disabled
// - Toggle output, or pulse in pulse mode
// - Pulse lasts two power width-field periods
package pacc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned PACC_ACC_W = 20;
    localparam int unsigned PACC_ADDR_W = 4;
    localparam int unsigned PACC_DATA_W = 8;
    localparam int unsigned PACC_SRC_N = 3;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] PACC_OFS_ACC_LOW = 4'h0;
    localparam logic [3:0] PACC_OFS_ACC_HIGH = 4'h1;
    localparam logic [3:0] PACC_OFS_ACC_UPPER = 4'h2;
    localparam logic [3:0] PACC_OFS_INC_LOW = 4'h3;
    localparam logic [3:0] PACC_OFS_INC_HIGH = 4'h4;
    localparam logic [3:0] PACC_OFS_INC_UPPER = 4'h5;
    localparam logic [3:0] PACC_OFS_CONTROL = 4'h6;
    localparam logic [3:0] PACC_OFS_CLOCK = 4'h7;
    localparam logic [3:0] PACC_OFS_STATUS = 4'h8;
    localparam logic [3:0] PACC_OFS_MASK = 4'h9;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned PACC_CTL_EN_BIT = 7;
    localparam int unsigned PACC_CTL_OUT_BIT = 5;
    localparam int unsigned PACC_CTL_POL_BIT = 4;
    localparam int unsigned PACC_CTL_PFM_BIT = 0;
    localparam int unsigned PACC_CLK_PWS_LSB = 5;
    localparam int unsigned PACC_CLK_CKS_LSB = 0;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [19:0] PACC_ACC_RST = 20'h0_0000;
    localparam logic [19:0] PACC_INC_RST = 20'h0_0001;
    localparam logic [7:0] PACC_PULSE_ONE = 8'h01;
    localparam logic [1:0] PACC_COMMIT_TICKS = 2'h2;
    localparam logic [1:0] PACC_CKS_RESERVED = 2'h3;
    // Pulse output state
    typedef enum logic [0:0] {
        PACC_PULSE_IDLE = 1'b0,
        PACC_PULSE_ACTIVE = 1'b1
    } pacc_pulse_t;
endpackage

// file: common/pacc_tick_if.sv
// ------------------------------------------------------------
// Oscillator clock select and edge tick
// ------------------------------------------------------------
interface pacc_tick_if;
    logic [1:0] clk_sel; // Source select from software
    logic tick; // One ref cycle per source rising edge
    modport src (input clk_sel, output tick);
    modport sink (output clk_sel, input tick);
endinterface

// file: design/pacc_clk_sel.sv
module pacc_clk_sel
    import pacc_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Raw oscillator sources
    input wire logic [PACC_SRC_N-1:0] i_osc_src,
    // Tick towards the core
    pacc_tick_if.src tick_if
);
    // ------------------------------------------------------------
    // Two-flop synchronisers, one per source
    // ------------------------------------------------------------
    logic [PACC_SRC_N-1:0] sync_meta; // First stage, read only by second
    logic [PACC_SRC_N-1:0] sync_lvl; // Safe levels
    logic sel_prev; // Selected level one cycle ago
    logic sel_lvl; // Selected synchronised level

    genvar g;
    generate
        for (g = 0; g < PACC_SRC_N; g++) begin : g_sync
            always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    sync_meta[g] <= 1'b0;
                    sync_lvl[g] <= 1'b0;
                end else begin
                    sync_meta[g] <= i_osc_src[g];
                    sync_lvl[g] <= sync_meta[g];
                end
            end
        end
    endgenerate

    // Reserved select gives a stopped clock
    always_comb begin
        if (tick_if.clk_sel == PACC_CKS_RESERVED) begin
            sel_lvl = 1'b0;
        end else begin
            sel_lvl = sync_lvl[tick_if.clk_sel];
        end
    end

    // Rising edge detect; source must stay below half the ref rate
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_prev <= 1'b0;
            tick_if.tick <= 1'b0;
        end else begin
            sel_prev <= sel_lvl;
            tick_if.tick <= sel_lvl & ~sel_prev;
        end
    end
endmodule

// file: testbench/pacc_tb.sv
module testbench
    import pacc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Signals towards the block
    // ------------------------------------------------------------
    logic i_ref_clk; // 100 MHz system clock
    logic i_reset_n; // Active low reset
    logic [PACC_ADDR_W-1:0] i_addr; // Register index
    logic [PACC_DATA_W-1:0] i_wr_data; // Write data
    logic i_wr_en; // Write strobe
    logic i_rd_en; // Read strobe
    logic [PACC_DATA_W-1:0] o_rd_data; // Read data, one cycle late
    logic [PACC_SRC_N-1:0] i_osc_src; // Only source 0 is exercised
    logic o_osc_out; // Oscillator output
    logic o_irq; // Level interrupt
    int failures; // Mismatch count
    int checks_done; // Comparison count
    int cnt; // Pulse width counter
    logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00}; // Reset readback per index
    logic [7:0] rw_tab [6] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h0F}; // All-ones readback
    // ------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------
    pacc_top uut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
        .i_osc_src(i_osc_src), .o_osc_out(o_osc_out), .o_irq(o_irq));
    // Clock generator
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Compare one byte and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1'b1;
        @(posedge i_ref_clk);
        i_wr_en <= 1'b0;
    endtask
    // Read strobe, data checked in the following cycle only
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        i_rd_en <= 1'b0;
        #1 chk(o_rd_data, exp);
    endtask
    // Whole 20-bit value over three byte registers, upper and high before low
    task automatic wr20(input logic [3:0] lo, input logic [19:0] v);
        wr(lo + 4'h2, {4'h0, v[19:16]});
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic rd_acc(input logic [19:0] v);
        rd(PACC_OFS_ACC_LOW, v[7:0]);
        rd(PACC_OFS_ACC_HIGH, v[15:8]);
        rd(PACC_OFS_ACC_UPPER, {4'h0, v[19:16]});
    endtask
    // Source edges, each level held four reference cycles so the sync sees it
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge i_ref_clk);
            i_osc_src[0] <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            i_osc_src[0] <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
        end
        repeat (2) @(posedge i_ref_clk);
    endtask
    // Verdict, reached from the tests and from the watchdog
    task automatic end_sim();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog at 60k cycles, about twice what the tests need
    initial begin
        #600_000;
        failures++;
        end_sim();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        i_reset_n = 1'b0;
        i_addr = 4'h0;
        i_wr_data = 8'h00;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        i_osc_src = 3'h0;
        failures = 0;
        checks_done = 0;
        repeat (12) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        // Reset values, then all-ones readback with unused bits dropped
        for (int a = 0; a < 10; a++) rd(4'(a), rst_tab[a]);
        for (int a = 0; a < 6; a++) wr(4'(a), 8'hFF);
        for (int a = 0; a < 6; a++) rd(4'(a), rw_tab[a]);
        wr(4'hA, 8'hFF);
        rd(4'hA, 8'h00);
        $display("test registers done");
        // Disabled load is immediate; three ticks accumulate the increment
        wr(PACC_OFS_CLOCK, 8'h00);
        wr20(PACC_OFS_INC_LOW, 20'h1_2345);
        wr20(PACC_OFS_ACC_LOW, 20'h0_0000);
        wr(PACC_OFS_CONTROL, 8'h80);
        edges(3);
        rd_acc(20'h3_69CF);
        $display("test accumulate done");
        // Enabled commit waits for the second tick
        wr(PACC_OFS_CONTROL, 8'h00);
        wr20(PACC_OFS_INC_LOW, 20'h0_0010);
        wr20(PACC_OFS_ACC_LOW, 20'h0_0000);
        wr(PACC_OFS_CONTROL, 8'h80);
        wr20(PACC_OFS_INC_LOW, 20'h0_0020);
        edges(1);
        rd_acc(20'h0_0010);
        edges(2);
        rd_acc(20'h0_0040);
        wr20(PACC_OFS_ACC_LOW, 20'h0_0000);
        edges(1);
        rd_acc(20'h0_0020);
        $display("test commit done");
        // Overflow toggles the output and sets the sticky flag
        wr(PACC_OFS_CONTROL, 8'h00);
        wr20(PACC_OFS_INC_LOW, 20'h8_0000);
        wr20(PACC_OFS_ACC_LOW, 20'h0_0000);
        wr(PACC_OFS_MASK, 8'h01);
        wr(PACC_OFS_CONTROL, 8'h80);
        edges(1);
        #1 chk({6'h0, o_osc_out, o_irq}, 8'h00);
        edges(1);
        #1 chk({6'h0, o_osc_out, o_irq}, 8'h03);
        rd(PACC_OFS_CONTROL, 8'hA0);
        rd(PACC_OFS_STATUS, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        #1 chk({7'h0, o_irq}, 8'h00);
        rd(PACC_OFS_STATUS, 8'h00);
        wr(PACC_OFS_MASK, 8'h00);
        edges(2);
        #1 chk({6'h0, o_osc_out, o_irq}, 8'h00);
        rd(PACC_OFS_STATUS, 8'h01);
        $display("test overflow done");
        // Pulse mode: width is 2^field source periods of eight cycles
        wr(PACC_OFS_CONTROL, 8'h00);
        wr20(PACC_OFS_INC_LOW, 20'h0_1000);
        for (int p = 0; p < 8; p++) begin
            wr(PACC_OFS_CLOCK, 8'(p << PACC_CLK_PWS_LSB));
            wr20(PACC_OFS_ACC_LOW, 20'h0_0000);
            wr(PACC_OFS_CONTROL, 8'h81);
            cnt = 0;
            fork
                edges(400);
                begin
                    for (int w = 0; w < 4000 && o_osc_out !== 1'b1; w++) begin
                        @(posedge i_ref_clk);
                        #1;
                    end
                    while (o_osc_out === 1'b1 && cnt < 2000) begin
                        cnt++;
                        @(posedge i_ref_clk);
                        #1;
                    end
                end
            join
            chk(8'(cnt >> 3), 8'(1 << p));
            wr(PACC_OFS_CONTROL, 8'h00);
        end
        $display("test pulse done");
        // Inverted polarity idles high; the reserved source gives no ticks
        wr(PACC_OFS_CONTROL, 8'h10);
        repeat (2) @(posedge i_ref_clk);
        #1 chk({7'h0, o_osc_out}, 8'h01);
        rd(PACC_OFS_CONTROL, 8'h30);
        wr(PACC_OFS_CLOCK, 8'h03);
        wr20(PACC_OFS_ACC_LOW, 20'h0_0000);
        wr(PACC_OFS_CONTROL, 8'h80);
        edges(2);
        rd(PACC_OFS_CLOCK, 8'h03);
        rd_acc(20'h0_0000);
        $display("test select done");
        end_sim();
    end
endmodule
